/* design/eeir_pkg.sv */
// Constants for the edge-enabled integrated RAM host controller
package eeir_pkg;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned CLK_PS = 25000;
  // Times in ns as printed (fastest grade), init time in us
  localparam int unsigned SEL_HOLD_NS = 40;
  localparam int unsigned CYCLE_NS = 425;
  localparam int unsigned STROBE_TO_REF_NS = 250;
  localparam int unsigned SEL_TO_REF_NS = 425;
  localparam int unsigned REF_PULSE_NS = 70;
  localparam int unsigned REF_PERIOD_MIN_NS = 350;
  localparam int unsigned REF_PERIOD_MAX_NS = 15600;
  localparam int unsigned REF_FALL_TO_SEL_NS = 350;
  localparam int unsigned EXT_RISE_TO_SEL_NS = 350;
  localparam int unsigned EXT_HIGH_NS = 425;
  localparam int unsigned EXT_PULSE_NS = 10000;
  localparam int unsigned DUMMY_LOW_MAX_NS = 10000;
  localparam int unsigned DUMMY_HIGH_NS = 200;
  localparam int unsigned INIT_US = 100;
  localparam int unsigned DATA_HOLD_NS = 40;
  localparam int unsigned ROWS = 128;
  localparam int unsigned ROW_BITS = 7;
  // Least times round up, longest round down
  function automatic int unsigned cyc_min(input int unsigned ns);
    cyc_min = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    if (cyc_min < 1) cyc_min = 1;
  endfunction : cyc_min
  function automatic int unsigned cyc_max(input int unsigned ns);
    cyc_max = (ns * 1000) / CLK_PS;
    if (cyc_max < 1) cyc_max = 1;
  endfunction : cyc_max
  localparam int unsigned SEL_HOLD_CYC = cyc_min(SEL_HOLD_NS);
  localparam int unsigned DATA_HOLD_CYC = cyc_min(DATA_HOLD_NS);
  localparam int unsigned CYCLE_CYC = cyc_min(CYCLE_NS);
  localparam int unsigned STROBE_TO_REF_CYC = cyc_min(STROBE_TO_REF_NS);
  localparam int unsigned SEL_TO_REF_CYC = cyc_min(SEL_TO_REF_NS);
  localparam int unsigned REF_PULSE_CYC = cyc_min(REF_PULSE_NS);
  localparam int unsigned REF_FALL_TO_SEL_CYC = cyc_min(REF_FALL_TO_SEL_NS);
  localparam int unsigned EXT_RISE_TO_SEL_CYC = cyc_min(EXT_RISE_TO_SEL_NS);
  localparam int unsigned EXT_HIGH_CYC = cyc_min(EXT_HIGH_NS);
  localparam int unsigned DUMMY_HIGH_CYC = cyc_min(DUMMY_HIGH_NS);
  localparam int unsigned EXT_PULSE_CYC = cyc_min(EXT_PULSE_NS);
  localparam int unsigned DUMMY_LOW_MAX_CYC = cyc_max(DUMMY_LOW_MAX_NS);
  localparam int unsigned REF_PERIOD_CYC = cyc_max(REF_PERIOD_MAX_NS);
  localparam int unsigned INIT_CYC = cyc_min(INIT_US * 1000);
  localparam int unsigned CNT_W = 16;
endpackage : eeir_pkg

/* design/eeir_host.sv */
// Host-side controller that drives the edge-enabled integrated RAM pins
`timescale 1ns/100ps
module eeir_host
  import eeir_pkg::*;
#(
  parameter int unsigned ADDR_W = 13,
  parameter int unsigned DATA_W = 8,
  parameter int unsigned INIT_CYCLES = INIT_CYC,
  parameter int unsigned EXT_CYCLES = EXT_PULSE_CYC,
  parameter int unsigned REF_PERIOD = REF_PERIOD_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_dummy,
  input wire logic req_hold,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  input wire logic hold_release,
  input wire logic standby,
  output logic busy,
  output logic [ADDR_W-1:0] mem_addr,
  output logic chip_sel_n,
  output logic out_en_n,
  output logic write_en_n,
  output logic refresh_request_n,
  output logic [DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe,
  input wire logic [DATA_W-1:0] mem_dq_i
);
  typedef enum logic [3:0] {
    S_INIT,
    S_IDLE,
    S_SETUP,
    S_ACC,
    S_STROBE,
    S_EXT,
    S_REC,
    S_REF,
    S_REFGAP,
    S_STBY
  } eeir_state_e;

  eeir_state_e st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] ref_q, ref_d;
  logic [CNT_W-1:0] ext_q, ext_d;
  logic write_q, write_d;
  logic dummy_q, dummy_d;
  logic extref_q, extref_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wd_q, wd_d;
  logic [DATA_W-1:0] rd_q, rd_d;
  logic ce_q, ce_d;
  logic oe_q, oe_d;
  logic we_q, we_d;
  logic rf_q, rf_d;
  logic dqe_q, dqe_d;
  logic rdy_q, rdy_d;
  logic rv_q, rv_d;
  logic hold_q, hold_d;
  logic busy_q, busy_d;
  // Room for a whole access taken just before refresh falls due
  localparam int unsigned REF_DUE = REF_PERIOD - CYCLE_CYC - CYCLE_CYC;

  // Saturating counter tick
  function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
    inc = (&v) ? v : v + 1'b1;
  endfunction : inc

  always_comb begin
    st_d = st_q;
    cnt_d = inc(cnt_q);
    ref_d = inc(ref_q);
    ext_d = ext_q;
    write_d = write_q;
    dummy_d = dummy_q;
    hold_d = hold_q;
    extref_d = extref_q;
    addr_d = addr_q;
    wd_d = wd_q;
    rd_d = rd_q;
    ce_d = ce_q;
    oe_d = oe_q;
    we_d = we_q;
    rf_d = rf_q;
    dqe_d = dqe_q;
    rdy_d = 1'b0;
    rv_d = 1'b0;
    case (st_q)
      S_INIT: begin
        rf_d = 1'b0;
        if (cnt_q >= CNT_W'(INIT_CYCLES)) begin
          rf_d = 1'b1;
          st_d = S_REFGAP;
          cnt_d = '0;
          ref_d = '0;
        end
      end
      S_IDLE: begin
        // Refresh gets priority so the period limit is never missed
        if (ref_q >= CNT_W'(REF_DUE)) begin
          rf_d = 1'b0;
          extref_d = 1'b0;
          st_d = S_REF;
          cnt_d = '0;
          ref_d = '0;
        end else if (req_valid && rdy_q) begin
          addr_d = req_addr;
          wd_d = req_wdata;
          write_d = req_write & ~req_dummy;
          dummy_d = req_dummy;
          hold_d = req_hold & ~req_dummy;
          st_d = S_SETUP;
          cnt_d = '0;
          if (req_write & ~req_dummy) begin
            dqe_d = 1'b1;
          end
        end else if (standby) begin
          rf_d = 1'b0;
          extref_d = 1'b1;
          st_d = S_STBY;
          cnt_d = '0;
        end else begin
          // Ready only when no refresh can win the next edge
          rdy_d = (ref_q + 1'b1 < CNT_W'(REF_DUE));
        end
      end
      S_SETUP: begin
        // Address and data settle one cycle before the edges
        ce_d = 1'b0;
        oe_d = ~(~write_q & ~dummy_q);
        we_d = ~write_q;
        st_d = S_ACC;
        cnt_d = '0;
      end
      S_ACC: begin
        if (cnt_q + 1'b1 >= CNT_W'(SEL_HOLD_CYC)) begin
          ce_d = 1'b1;
          st_d = hold_q ? S_EXT : S_STROBE;
        end
      end
      S_STROBE: begin
        if (cnt_q + 1'b1 >= CNT_W'(STROBE_TO_REF_CYC)) begin
          if (!oe_q) begin
            rd_d = mem_dq_i;
            rv_d = 1'b1;
          end
          oe_d = 1'b1;
          we_d = 1'b1;
          dqe_d = 1'b0;
          st_d = S_REC;
        end
      end
      S_EXT: begin
        // Strobe stays low; select is already high
        if (!oe_q) begin
          rd_d = mem_dq_i;
        end
        if (cnt_q >= CNT_W'(SEL_TO_REF_CYC) && rf_q) begin
          rf_d = 1'b0;
          ext_d = '0;
        end
        if (!rf_q) begin
          ext_d = inc(ext_q);
          ref_d = '0;
        end
        if (!we_q && cnt_q >= CNT_W'(DATA_HOLD_CYC)) begin
          dqe_d = 1'b0;
        end
        if (hold_release && !rf_q && ext_q >= CNT_W'(EXT_CYCLES)) begin
          rv_d = ~oe_q;
          oe_d = 1'b1;
          we_d = 1'b1;
          dqe_d = 1'b0;
          rf_d = 1'b1;
          extref_d = 1'b1;
          st_d = S_REFGAP;
          cnt_d = '0;
        end
      end
      S_REC: begin
        // Full cycle time before any next select or refresh
        if (cnt_q >= CNT_W'(dummy_q ? SEL_TO_REF_CYC : CYCLE_CYC)) begin
          st_d = S_IDLE;
          cnt_d = '0;
        end
      end
      S_REF: begin
        if (cnt_q + 1'b1 >= CNT_W'(REF_PULSE_CYC)) begin
          rf_d = 1'b1;
          st_d = S_REFGAP;
        end
      end
      S_STBY: begin
        ref_d = '0;
        if (!standby && cnt_q >= CNT_W'(EXT_CYCLES)) begin
          rf_d = 1'b1;
          st_d = S_REFGAP;
          cnt_d = '0;
        end
      end
      S_REFGAP: begin
        // Select stays high while refresh runs inside the device
        if (cnt_q >= CNT_W'(extref_q ? EXT_HIGH_CYC : REF_FALL_TO_SEL_CYC)) begin
          extref_d = 1'b0;
          st_d = S_IDLE;
          cnt_d = '0;
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
    busy_d = ~rdy_d;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_INIT;
      cnt_q <= '0;
      ref_q <= '0;
      ext_q <= '0;
      write_q <= 1'b0;
      dummy_q <= 1'b0;
      hold_q <= 1'b0;
      extref_q <= 1'b0;
      addr_q <= '0;
      wd_q <= '0;
      rd_q <= '0;
      ce_q <= 1'b1;
      oe_q <= 1'b1;
      we_q <= 1'b1;
      rf_q <= 1'b1;
      dqe_q <= 1'b0;
      rdy_q <= 1'b0;
      rv_q <= 1'b0;
      busy_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ref_q <= ref_d;
      ext_q <= ext_d;
      write_q <= write_d;
      dummy_q <= dummy_d;
      hold_q <= hold_d;
      extref_q <= extref_d;
      addr_q <= addr_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      ce_q <= ce_d;
      oe_q <= oe_d;
      we_q <= we_d;
      rf_q <= rf_d;
      dqe_q <= dqe_d;
      rdy_q <= rdy_d;
      rv_q <= rv_d;
      busy_q <= busy_d;
    end
  end

  assign req_ready = rdy_q;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rd_q;
  // Own flop so the pin never shows a gate glitch
  assign busy = busy_q;
  assign mem_addr = addr_q;
  assign chip_sel_n = ce_q;
  assign out_en_n = oe_q;
  assign write_en_n = we_q;
  assign refresh_request_n = rf_q;
  assign mem_dq_o = wd_q;
  assign mem_dq_oe = dqe_q;
endmodule : eeir_host

/* tb/eeir_host_asserts.sv */
// Pin timing checks for the host controller
`timescale 1ns/100ps
module eeir_host_asserts #(
  parameter int unsigned DATA_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic write_en_n,
  input wire logic refresh_request_n,
  input wire logic mem_dq_oe,
  input wire logic [DATA_W-1:0] mem_dq_o
);
  logic rr_q, cs_q, rr_d, cs_d;
  logic [4:0] ref_age_q, ref_age_d, sel_age_q, sel_age_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Ages saturate so long idle spells stay legal
  always_comb begin
    rr_d = refresh_request_n;
    cs_d = chip_sel_n;
    ref_age_d = (ref_age_q == 5'h1f) ? ref_age_q : ref_age_q + 5'h01;
    sel_age_d = (sel_age_q == 5'h1f) ? sel_age_q : sel_age_q + 5'h01;
    if (rr_q && !refresh_request_n) ref_age_d = 5'h00;
    if (cs_q && !chip_sel_n) sel_age_d = 5'h00;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rr_q <= 1'b1;
      cs_q <= 1'b1;
      ref_age_q <= 5'h1f;
      sel_age_q <= 5'h1f;
    end else begin
      rr_q <= rr_d;
      cs_q <= cs_d;
      ref_age_q <= ref_age_d;
      sel_age_q <= sel_age_d;
    end
  end
  property p_no_both;
    !(!out_en_n && !write_en_n);
  endproperty
  a_no_both: assert property (p_no_both) else $error("read and write strobes low together");
  property p_read_hold;
    $fell(out_en_n) |-> $fell(chip_sel_n) ##1 !chip_sel_n;
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read select start or hold bad");
  property p_write_hold;
    $fell(write_en_n) |-> $fell(chip_sel_n) ##1 !chip_sel_n;
  endproperty
  a_write_hold: assert property (p_write_hold) else $error("write select start or hold bad");
  property p_wdata;
    $fell(write_en_n) |-> (mem_dq_oe && $stable(mem_dq_o)) [*2];
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data not held");
  property p_ref_pulse;
    $fell(refresh_request_n) |-> !refresh_request_n [*3];
  endproperty
  a_ref_pulse: assert property (p_ref_pulse) else $error("refresh pulse short");
  property p_ref_to_sel;
    $fell(chip_sel_n) |-> refresh_request_n && ref_age_q >= 5'h0d;
  endproperty
  a_ref_to_sel: assert property (p_ref_to_sel) else $error("select too near refresh");
  property p_sel_to_ref;
    $fell(refresh_request_n) |-> sel_age_q >= 5'h10;
  endproperty
  a_sel_to_ref: assert property (p_sel_to_ref) else $error("refresh too near select");
  property p_sel_high;
    $rose(chip_sel_n) |-> chip_sel_n [*8];
  endproperty
  a_sel_high: assert property (p_sel_high) else $error("select high time short");
  cover property ($fell(out_en_n));
  cover property ($fell(write_en_n));
  cover property ($fell(chip_sel_n) && out_en_n && write_en_n);
endmodule : eeir_host_asserts
bind eeir_host eeir_host_asserts #(.DATA_W(DATA_W)) chk_u (.clk(clk), .rst_n(rst_n),
  .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
  .refresh_request_n(refresh_request_n), .mem_dq_oe(mem_dq_oe), .mem_dq_o(mem_dq_o));

/* tb/eeir_ram_model.sv */
// Behavioural model of the edge-enabled RAM device
`timescale 1ns/100ps
module eeir_ram_model #(
  parameter int EXT_NS = 250
) (
  input wire logic [12:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic ref_n,
  input wire logic [7:0] dq_host,
  input wire logic dq_oe,
  output logic [7:0] dq_dev
);
  logic [7:0] mem [0:8191];
  logic [12:0] a_q;
  logic [7:0] last;
  int ref_cnt = 0, ext_cnt = 0, row_hits = 0;
  time ref_t;
  // Edge only, so pulse and level select both work
  always @(negedge ce_n) begin
    a_q = addr;
    #1 if (oe_n && we_n) row_hits++;
  end
  always @(negedge we_n) #1 mem[a_q] = dq_host;
  // Released bus shows the inverse, never a stale value
  assign dq_dev = !oe_n ? mem[a_q] : dq_oe ? dq_host : ~last;
  always @* if (!oe_n) last = mem[a_q]; else if (dq_oe) last = dq_host;
  always @(negedge ref_n) begin
    ref_cnt++;
    ref_t = $time;
  end
  always @(posedge ref_n) if ($time - ref_t >= EXT_NS) ext_cnt++;
endmodule : eeir_ram_model

/* tb/eeir_host_bench.sv */
// Self-checking bench for the host controller
`timescale 1ns/100ps
module eeir_host_bench;
  import eeir_pkg::*;
  logic clk, rst_n, req_valid, req_write, req_dummy, req_hold, hold_release, standby;
  logic [12:0] req_addr, mem_addr;
  logic [7:0] req_wdata, rsp_rdata, dq_o, dq_i;
  logic req_ready, rsp_valid, busy, cs_n, oe_n, we_n, rr_n, dq_oe;
  int mismatches = 0, total_checks = 0, cyc = 0, k;
  eeir_host #(.INIT_CYCLES(20), .EXT_CYCLES(10), .REF_PERIOD(60)) dut_u (.clk(clk),
    .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write), .req_dummy(req_dummy),
    .req_hold(req_hold), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .hold_release(hold_release),
    .standby(standby), .busy(busy), .mem_addr(mem_addr), .chip_sel_n(cs_n),
    .out_en_n(oe_n), .write_en_n(we_n), .refresh_request_n(rr_n), .mem_dq_o(dq_o),
    .mem_dq_oe(dq_oe), .mem_dq_i(dq_i));
  eeir_ram_model #(.EXT_NS(250)) mem_u (.addr(mem_addr), .ce_n(cs_n), .oe_n(oe_n),
    .we_n(we_n), .ref_n(rr_n), .dq_host(dq_o), .dq_oe(dq_oe), .dq_dev(dq_i));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic fail(input string m);
    mismatches++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : fail
  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) fail("data mismatch");
  endtask : chk_data
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) fail("pin level wrong");
  endtask : chk_bit
  task automatic chk_cnt(input int got, input int least);
    total_checks++;
    if (got < least) fail("count too low");
  endtask : chk_cnt
  // Holds the request until an edge sees ready high
  task automatic issue(input logic w, d, h, input logic [12:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_dummy <= d;
    req_hold <= h;
    req_addr <= a;
    req_wdata <= v;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 500);
    req_valid <= 1'b0;
    if (n >= 500) fail("request not taken");
  endtask : issue
  task automatic wait_rsp;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 500);
    if (n >= 500) fail("no read answer");
  endtask : wait_rsp
  task automatic t_write_read;
    issue(1'b1, 1'b0, 1'b0, 13'h0000, 8'h5a);
    issue(1'b1, 1'b0, 1'b0, 13'h1fff, 8'ha5);
    issue(1'b0, 1'b0, 1'b0, 13'h0000, 8'h00);
    wait_rsp();
    chk_data(rsp_rdata, 8'h5a);
    issue(1'b0, 1'b0, 1'b0, 13'h1fff, 8'h00);
    wait_rsp();
    chk_data(rsp_rdata, 8'ha5);
  endtask : t_write_read
  task automatic t_dummy;
    k = mem_u.row_hits;
    issue(1'b1, 1'b1, 1'b0, 13'h1fff, 8'h33);
    issue(1'b0, 1'b0, 1'b0, 13'h1fff, 8'h00);
    wait_rsp();
    chk_cnt(mem_u.row_hits, k + 1);
    chk_data(rsp_rdata, 8'ha5);
  endtask : t_dummy
  task automatic t_extended;
    k = mem_u.ext_cnt;
    hold_release <= 1'b0;
    issue(1'b0, 1'b0, 1'b1, 13'h0000, 8'h00);
    repeat (30) @(posedge clk);
    chk_data(dq_i, 8'h5a);
    chk_bit(rr_n, 1'b0);
    hold_release <= 1'b1;
    wait_rsp();
    hold_release <= 1'b0;
    chk_data(rsp_rdata, 8'h5a);
    chk_cnt(mem_u.ext_cnt, k + 1);
  endtask : t_extended
  task automatic t_standby;
    @(posedge clk);
    standby <= 1'b1;
    repeat (60) @(posedge clk);
    chk_bit(rr_n, 1'b0);
    chk_bit(busy, 1'b1);
    standby <= 1'b0;
  endtask : t_standby
  task automatic t_refresh;
    // Idle controller must strobe at least 4 times in 215 cycles
    k = mem_u.ref_cnt;
    repeat (215) @(posedge clk);
    chk_cnt(mem_u.ref_cnt, k + 4);
  endtask : t_refresh
  initial begin
    rst_n = 1'b0;
    {req_valid, req_write, req_dummy, req_hold, hold_release, standby} = 6'h00;
    req_addr = 13'h0000;
    req_wdata = 8'h00;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_write_read();
    t_dummy();
    t_extended();
    t_standby();
    t_refresh();
    complete_run();
  end
endmodule : eeir_host_bench
